//--- ivh_top.sv
// VMEbus interrupt handler, internal router and VME software interrupter.
// Assumes all inputs are synchronous to pclk; APB slave on an 8-bit address.
`timescale 1ns/100ps
`include "ivh_consts.svh"

module ivh_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:1]  vme_irq_n,
  input  wire logic        sysfail_n,
  input  wire logic        acfail_n,
  input  wire logic        tgt_req,
  input  wire logic        dma_req,
  output logic             tgt_gnt,
  output logic             dma_gnt,
  output logic             int_gnt,
  output logic [1:0]       vme_breq_level,
  output logic             ack_cycle_error_flag_req,
  output logic [2:0]       ack_cycle_error_flag_lvl,
  input  wire logic        ack_cycle_error_flag_done,
  input  wire logic        ack_cycle_error_flag_berr,
  input  wire logic [7:0]  ack_cycle_error_flag_statid,
  input  wire logic        sw_ack_done,
  input  wire logic [2:0]  sw_ack_lvl,
  input  wire logic        dma_evt,
  input  wire logic        mbox_evt,
  input  wire logic        abort_evt,
  input  wire logic        lm_evt,
  input  wire logic        own_evt,
  output logic [7:0]       host_irq_out_lines,
  output logic [7:1]       vme_irq_out
);

  // **************************************************************************
  // State and helpers
  // **************************************************************************
  ivh_pkg::ivh_state_t r_q;
  ivh_pkg::ivh_state_t r_d;

  logic [7:0]  act;
  logic        act_any;
  logic [2:0]  act_lvl;
  logic [7:0]  lvl_hot [1:7];
  logic [7:0]  src_hot [0:`IVH_NSRC_PCI-1];
  logic [7:0]  vsrc_hot [0:`IVH_NSRC_VME-1];
  logic        wr;
  logic        rd;
  logic [31:0] rdval;
  logic        hit;
  logic [2:0]  hidx;
  logic [31:0] lset;
  logic [31:0] vset;
  logic [31:0] vclr;
  logic        done_ok;
  logic        swm_hit;
  logic        int_want;
  logic        own_free;

  // Only enabled, armed, asserted levels compete; fail lines never enter here
  assign act = {~vme_irq_n & r_q.len[7:1] & ~r_q.held[7:1], 1'b0};

  ivh_lvl_pick u_pick (
    .req (act),
    .any (act_any),
    .lvl (act_lvl)
  );

  // **************************************************************************
  // Routing decoders
  // **************************************************************************
  genvar g;
  generate
    for (g = `IVH_LVL_LO; g <= `IVH_LVL_HI; g++) begin : g_lvl
      ivh_map_dec u_dec (
        .en  (r_q.lstat[g] & r_q.len[g]),
        .sel (r_q.lmap[`IVH_MAP_W*g +: `IVH_MAP_W]),
        .hot (lvl_hot[g])
      );
    end
    for (g = 0; g < `IVH_NSRC_PCI; g++) begin : g_src
      ivh_map_dec u_dec (
        .en  (r_q.lstat[`IVH_B_SYSF+g] & r_q.len[`IVH_B_SYSF+g]),
        .sel (r_q.smap[`IVH_MAP_W*g +: `IVH_MAP_W]),
        .hot (src_hot[g])
      );
    end
    for (g = 0; g < `IVH_NSRC_VME; g++) begin : g_vsrc
      ivh_map_dec u_dec (
        .en  (r_q.vstat[`IVH_V_SWM+g] & r_q.ven[`IVH_V_SWM+g]),
        .sel (r_q.vmap[`IVH_VMAP_STEP*g +: `IVH_MAP_W]),
        .hot (vsrc_hot[g])
      );
    end
  endgenerate

  // **************************************************************************
  // APB decode
  // **************************************************************************
  // Two-cycle access phase: pready rises one edge after penable, and the
  // write lands on the edge that samples it, so nothing commits early.
  assign wr   = psel & penable & pwrite & r_q.pready;
  assign rd   = psel & penable & ~r_q.pready;
  assign hidx = paddr[4:2];

  always_comb begin
    hit   = 1'b1;
    rdval = `IVH_RST_WORD;
    unique case (paddr)
      `IVH_OFF_LEN:   rdval = r_q.len;
      `IVH_OFF_LSTAT: rdval = r_q.lstat;
      `IVH_OFF_LMAP:  rdval = r_q.lmap;
      `IVH_OFF_SMAP:  rdval = r_q.smap;
      `IVH_OFF_VEN:   rdval = r_q.ven;
      `IVH_OFF_VSTAT: rdval = r_q.vstat;
      `IVH_OFF_VMAP:  rdval = r_q.vmap;
      `IVH_OFF_MCTL:  rdval = r_q.mctl;
      `IVH_OFF_AMLOG: rdval = {28'h0, r_q.am_lvl, r_q.am_flag};
      default: begin
        if (paddr[7:5] == `IVH_HOLD_BASE && paddr[1:0] == 2'h0 && hidx != `IVH_HOLD_LAST)
          rdval = {23'h0, r_q.hold[hidx + 3'h1]};
        else
          hit = 1'b0;
      end
    endcase
  end

  // **************************************************************************
  // Next-state logic
  // **************************************************************************
  assign done_ok  = (r_q.fsm == ivh_pkg::IVH_ACK) & ack_cycle_error_flag_done;
  assign int_want = (r_q.fsm != ivh_pkg::IVH_IDLE);
  assign own_free = (r_q.own == ivh_pkg::IVH_OWN_NONE)
                  | ((r_q.own == ivh_pkg::IVH_OWN_TGT) & ~tgt_req)
                  | ((r_q.own == ivh_pkg::IVH_OWN_DMA) & ~dma_req)
                  | ((r_q.own == ivh_pkg::IVH_OWN_INT) & ~int_want);
  assign swm_hit  = r_q.vstat[`IVH_V_SWM] & (r_q.vmap[`IVH_MAP_W-1:0] == sw_ack_lvl);

  always_comb begin
    r_d         = r_q;
    r_d.pready  = rd;
    r_d.pslverr = rd & ~hit;
    if (rd)
      r_d.prdata = rdval;
    lset = `IVH_RST_WORD;
    vset = `IVH_RST_WORD;
    vclr = `IVH_RST_WORD;

    // Owner keeps the interface until it drops its request; no preemption
    if (own_free) begin
      if (int_want)
        r_d.own = ivh_pkg::IVH_OWN_INT;
      else if (tgt_req)
        r_d.own = ivh_pkg::IVH_OWN_TGT;
      else if (dma_req)
        r_d.own = ivh_pkg::IVH_OWN_DMA;
      else
        r_d.own = ivh_pkg::IVH_OWN_NONE;
    end

    unique case (r_q.fsm)
      ivh_pkg::IVH_IDLE: begin
        if (act_any) begin
          r_d.cur = act_lvl;
          r_d.fsm = ivh_pkg::IVH_REQ;
        end
      end
      ivh_pkg::IVH_REQ: begin
        // Level stays latched even if a higher one asserts meanwhile
        if (r_q.own == ivh_pkg::IVH_OWN_INT) begin
          r_d.ack_cycle_error_flag_req = 1'b1;
          r_d.fsm      = ivh_pkg::IVH_ACK;
        end
      end
      ivh_pkg::IVH_ACK: begin
        if (ack_cycle_error_flag_done) begin
          r_d.ack_cycle_error_flag_req = 1'b0;
          r_d.hold[r_q.cur] = {ack_cycle_error_flag_berr, ack_cycle_error_flag_statid};
          r_d.held[r_q.cur] = 1'b1;
          lset[r_q.cur]     = 1'b1;
          if (ack_cycle_error_flag_berr) begin
            r_d.am_flag = 1'b1;
            r_d.am_lvl  = r_q.cur;
            lset[`IVH_B_VME_BUS_ERROR_SOURCE] = r_q.len[`IVH_B_VME_BUS_ERROR_SOURCE];
            vset[`IVH_V_VME_BUS_ERROR_SOURCE] = r_q.ven[`IVH_V_VME_BUS_ERROR_SOURCE];
          end
          r_d.fsm = ivh_pkg::IVH_SEL;
        end
      end
      ivh_pkg::IVH_SEL: begin
        // Bus is still ours: go straight on to the highest armed level
        if (act_any) begin
          r_d.cur      = act_lvl;
          r_d.ack_cycle_error_flag_req = 1'b1;
          r_d.fsm      = ivh_pkg::IVH_ACK;
        end else begin
          r_d.fsm = ivh_pkg::IVH_IDLE;
        end
      end
    endcase

    // Fail lines are status only and never produce an acknowledge
    lset[`IVH_B_SYSF] = ~sysfail_n & r_q.len[`IVH_B_SYSF];
    lset[`IVH_B_ACF]  = ~acfail_n & r_q.len[`IVH_B_ACF];
    lset[`IVH_B_DMA]  = dma_evt & r_q.len[`IVH_B_DMA];
    lset[`IVH_B_MBOX] = mbox_evt & r_q.len[`IVH_B_MBOX];
    lset[`IVH_B_ABRT] = abort_evt & r_q.len[`IVH_B_ABRT];
    lset[`IVH_B_LM]   = lm_evt & r_q.len[`IVH_B_LM];
    lset[`IVH_B_OWN]  = own_evt & r_q.len[`IVH_B_OWN];
    vset[`IVH_V_DMA]  = dma_evt & r_q.ven[`IVH_V_DMA];
    vset[`IVH_V_MBOX] = mbox_evt & r_q.ven[`IVH_V_MBOX];
    vset[`IVH_V_ABRT] = abort_evt & r_q.ven[`IVH_V_ABRT];

    // Software acknowledge: the mappable source owns a shared level
    if (sw_ack_done) begin
      if (swm_hit)
        vclr[`IVH_V_SWM] = 1'b1;
      else if (r_q.vstat[sw_ack_lvl] && sw_ack_lvl != 3'h0)
        vclr[sw_ack_lvl] = 1'b1;
      lset[`IVH_B_SACK] = (|vclr) & r_q.len[`IVH_B_SACK];
    end

    if (wr) begin
      unique case (paddr)
        `IVH_OFF_LEN:  r_d.len  = pwdata & `IVH_LEN_MASK;
        `IVH_OFF_LMAP: r_d.lmap = pwdata & `IVH_LMAP_MASK;
        `IVH_OFF_SMAP: r_d.smap = pwdata & `IVH_SMAP_MASK;
        `IVH_OFF_VMAP: r_d.vmap = pwdata & `IVH_VMAP_MASK;
        `IVH_OFF_MCTL: r_d.mctl = pwdata & `IVH_MCTL_MASK;
        `IVH_OFF_AMLOG: begin
          r_d.am_flag = 1'b0;
          r_d.am_lvl  = 3'h0;
        end
        `IVH_OFF_LSTAT: begin
          r_d.lstat = r_q.lstat & ~(pwdata & `IVH_LEN_MASK);
          // Clearing a level bit also re-arms that level
          r_d.held  = r_q.held & ~pwdata[7:0] & `IVH_LVL_MASK;
        end
        `IVH_OFF_VSTAT: vclr = vclr | (pwdata & `IVH_VW1C_MASK);
        `IVH_OFF_VEN: begin
          r_d.ven = pwdata & `IVH_VEN_MASK;
          // Only a rising software bit fires; a held one does nothing
          vset = vset | (pwdata & ~r_q.ven & `IVH_SW_MASK);
        end
        default: begin
        end
      endcase
    end

    // Sets win over clears arriving in the same cycle
    if (done_ok)
      r_d.held[r_q.cur] = 1'b1;
    r_d.lstat = r_d.lstat | lset;
    r_d.vstat = (r_q.vstat & ~vclr) | vset;

    r_d.host_irq = 8'h00;
    for (int i = `IVH_LVL_LO; i <= `IVH_LVL_HI; i++)
      r_d.host_irq = r_d.host_irq | lvl_hot[i];
    for (int i = 0; i < `IVH_NSRC_PCI; i++)
      r_d.host_irq = r_d.host_irq | src_hot[i];

    // Per-level software bits drive their own level directly
    r_d.vme_irq = r_q.vstat[7:0] & r_q.ven[7:0] & `IVH_LVL_MASK;
    for (int i = 0; i < `IVH_NSRC_VME; i++)
      r_d.vme_irq = r_d.vme_irq | (vsrc_hot[i] & `IVH_LVL_MASK);
  end

  // **************************************************************************
  // State register
  // **************************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  assign prdata             = r_q.prdata;
  assign pready             = r_q.pready;
  assign pslverr            = r_q.pslverr;
  assign tgt_gnt            = (r_q.own == ivh_pkg::IVH_OWN_TGT);
  assign dma_gnt            = (r_q.own == ivh_pkg::IVH_OWN_DMA);
  assign int_gnt            = (r_q.own == ivh_pkg::IVH_OWN_INT);
  assign vme_breq_level     = r_q.mctl[`IVH_BRL_W-1:0];
  assign ack_cycle_error_flag_req           = r_q.ack_cycle_error_flag_req;
  assign ack_cycle_error_flag_lvl           = r_q.cur;
  assign host_irq_out_lines = r_q.host_irq;
  assign vme_irq_out        = r_q.vme_irq[7:1];

endmodule

//--- ivh_consts.svh
// Constants for the VMEbus interrupt handler and internal interrupt router.
// Assumes a 32-bit APB slave on an 8-bit byte address; included by bare name.
//
// What this block does
// - Software enables watching IRQ levels and both fail lines; fail lines never acknowledged.
// - An enabled asserted level requests the master interface at the programmed request level.
// - Interrupt channel beats target and DMA channels, waiting for the current owner.
// - The first detected level is latched and acknowledged first, even if higher arrives.
// - After that, the highest remaining active armed level is acknowledged next.
// - A level reaches the PCI outputs only after its acknowledge cycle completed.
// - Each acknowledge stores its vector in that level's own holding register.
// - A latched level gets no new acknowledge until software writes one to re-arm.
// - Other pending levels keep being acknowledged in priority order meanwhile.
// - Stored vector raises the mapped PCI line; clearing its status clears and re-arms.
// - Bus error in acknowledge logs with the ack flag and raises the VME error source.
// - Vector fetch error sets the holding error flag; PCI interrupt raised anyway.
// - After a fetch error both level status and VME error status read active.
// - Sources route: some to either bus, software to VME only, others PCI only.
// - Writing one to a zero per-level software bit asserts that VME IRQ level.
// - Zero-to-one write of the mappable software bit raises one IRQ at mapped level.
// - Mappable software interrupt beats per-level software interrupt on the same level.
// - Mappable software status stays set while that source is active.
// - Software interrupt bits trigger only on a zero-to-one write.
// - Serviced software acknowledge raises a PCI interrupt when its enable is set.
// - Software interrupt status and line release automatically on acknowledge completion.
`ifndef IVH_CONSTS_SVH
`define IVH_CONSTS_SVH

// ****************************************************************************
// Register offsets (byte addresses)
// ****************************************************************************
`define IVH_OFF_LEN    8'h00
`define IVH_OFF_LSTAT  8'h04
`define IVH_OFF_LMAP   8'h08
`define IVH_OFF_SMAP   8'h0C
`define IVH_OFF_VEN    8'h10
`define IVH_OFF_VSTAT  8'h14
`define IVH_OFF_VMAP   8'h18
`define IVH_OFF_MCTL   8'h1C
`define IVH_OFF_AMLOG  8'h20
`define IVH_HOLD_BASE  3'h2
`define IVH_HOLD_LAST  3'h7

// ****************************************************************************
// Field layout
// ****************************************************************************
`define IVH_B_SYSF     8
`define IVH_B_ACF      9
`define IVH_B_VME_BUS_ERROR_SOURCE     10
`define IVH_B_DMA      11
`define IVH_B_MBOX     12
`define IVH_B_ABRT     13
`define IVH_B_SACK     14
`define IVH_B_LM       15
`define IVH_B_OWN      16
`define IVH_NSRC_PCI   9
`define IVH_V_SWM      8
`define IVH_V_VME_BUS_ERROR_SOURCE     9
`define IVH_V_DMA      10
`define IVH_V_MBOX     11
`define IVH_V_ABRT     12
`define IVH_NSRC_VME   5
`define IVH_MAP_W      3
`define IVH_VMAP_STEP  4
`define IVH_HOLD_ERR   8
`define IVH_AM_FLAG    0
`define IVH_AM_LVL     1
`define IVH_BRL_W      2
`define IVH_LVL_LO     1
`define IVH_LVL_HI     7

// ****************************************************************************
// Writable masks and reset values
// ****************************************************************************
`define IVH_LEN_MASK   32'h0001_FFFE
`define IVH_LMAP_MASK  32'h00FF_FFF8
`define IVH_SMAP_MASK  32'h07FF_FFFF
`define IVH_VEN_MASK   32'h0000_1FFE
`define IVH_VW1C_MASK  32'h0000_1E00
`define IVH_VMAP_MASK  32'h0007_7777
`define IVH_MCTL_MASK  32'h0000_0003
`define IVH_SW_MASK    32'h0000_01FE
`define IVH_LVL_MASK   8'hFE
`define IVH_RST_WORD   32'h0000_0000

`endif

//--- ivh_pkg.sv
// Types for the interrupt handler and router.
// Assumes ivh_consts.svh is available for field widths.
`include "ivh_consts.svh"

package ivh_pkg;

  typedef enum logic [1:0] {
    IVH_IDLE,
    IVH_REQ,
    IVH_ACK,
    IVH_SEL
  } ivh_fsm_t;

  typedef enum logic [1:0] {
    IVH_OWN_NONE,
    IVH_OWN_INT,
    IVH_OWN_TGT,
    IVH_OWN_DMA
  } ivh_own_t;

  typedef struct packed {
    ivh_fsm_t         fsm;
    ivh_own_t         own;
    logic [2:0]       cur;
    logic [7:0]       held;
    logic [7:0][8:0]  hold;
    logic [31:0]      len, lstat, lmap, smap, ven, vstat, vmap, mctl;
    logic             am_flag;
    logic [2:0]       am_lvl;
    logic             ack_cycle_error_flag_req;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic [7:0]       host_irq;
    logic [7:0]       vme_irq;
  } ivh_state_t;

endpackage

//--- ivh_lvl_pick.sv
// Highest-level selector over a request vector; bit 0 is never a level.
// Purely combinational, read by the registered logic of the top.
`timescale 1ns/100ps
`include "ivh_consts.svh"

module ivh_lvl_pick (
  input  wire logic [7:0] req,
  output logic            any,
  output logic [2:0]      lvl
);

  always_comb begin
    any = 1'b0;
    lvl = 3'h0;
    for (int i = `IVH_LVL_LO; i <= `IVH_LVL_HI; i++) begin
      if (req[i]) begin
        any = 1'b1;
        lvl = 3'(i);
      end
    end
  end

endmodule

//--- ivh_map_dec.sv
// Map-field decoder: turns a 3-bit line or level number into a one-hot vector.
// For VME levels the caller ignores bit 0, so a level of zero disables.
`timescale 1ns/100ps

module ivh_map_dec (
  input  wire logic       en,
  input  wire logic [2:0] sel,
  output logic [7:0]      hot
);

  assign hot = en ? (8'h01 << sel) : 8'h00;

endmodule

//--- ivh_top_chk.sv
// Port-level timing checks for the interrupt handler top.
// Assumes it is bound to ivh_top and sees only that module's ports.
`timescale 1ns/100ps

module ivh_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       tgt_req,
  input wire logic       dma_req,
  input wire logic       tgt_gnt,
  input wire logic       dma_gnt,
  input wire logic       int_gnt,
  input wire logic       ack_cycle_error_flag_req,
  input wire logic [2:0] ack_cycle_error_flag_lvl,
  input wire logic       ack_cycle_error_flag_done,
  input wire logic       ack_cycle_error_flag_berr,
  input wire logic       sw_ack_done
);
  // *****
  // Assertions
  // *****
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_one_owner: assert property ($onehot0({tgt_gnt, dma_gnt, int_gnt}))
    else $error("two owners of master interface");
  a_ack_owned: assert property (ack_cycle_error_flag_req |-> int_gnt)
    else $error("ack cycle without interrupt grant");
  a_ack_level: assert property (ack_cycle_error_flag_req |-> ack_cycle_error_flag_lvl inside {[3'h1:3'h7]})
    else $error("ack cycle on a non-level");
  a_lvl_held: assert property (ack_cycle_error_flag_req && !ack_cycle_error_flag_done |=> $stable(ack_cycle_error_flag_lvl))
    else $error("ack level moved mid-cycle");
  a_done_ends: assert property (ack_cycle_error_flag_req && ack_cycle_error_flag_done |=> !ack_cycle_error_flag_req)
    else $error("ack request outlived done");
  a_grant_first: assert property ($rose(ack_cycle_error_flag_req) |-> $past(int_gnt))
    else $error("ack request before grant");
  a_tgt_kept: assert property (tgt_gnt && tgt_req |=> tgt_gnt && !int_gnt)
    else $error("target owner preempted");
  a_dma_kept: assert property (dma_gnt && dma_req |=> dma_gnt && !int_gnt)
    else $error("dma owner preempted");

  c_berr: cover property (ack_cycle_error_flag_req && ack_cycle_error_flag_done && ack_cycle_error_flag_berr);
  c_ok: cover property (ack_cycle_error_flag_req && ack_cycle_error_flag_done && !ack_cycle_error_flag_berr);
  c_wait: cover property (tgt_gnt && tgt_req ##1 tgt_gnt);
  c_swack: cover property (sw_ack_done);
endmodule

bind ivh_top ivh_chk chk_u (
  .pclk(pclk), .presetn(presetn), .tgt_req(tgt_req), .dma_req(dma_req),
  .tgt_gnt(tgt_gnt), .dma_gnt(dma_gnt), .int_gnt(int_gnt), .ack_cycle_error_flag_req(ack_cycle_error_flag_req),
  .ack_cycle_error_flag_lvl(ack_cycle_error_flag_lvl), .ack_cycle_error_flag_done(ack_cycle_error_flag_done), .ack_cycle_error_flag_berr(ack_cycle_error_flag_berr),
  .sw_ack_done(sw_ack_done)
);

//--- ivh_ack_cycle_error_flag_model.sv
// Far-side model: master interface running acknowledge cycles on the bus.
// Assumes ack_cycle_error_flag_req is held until the edge that samples ack_cycle_error_flag_done.
`timescale 1ns/100ps

module ivh_ack_cycle_error_flag_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ack_cycle_error_flag_req,
  input  wire logic [2:0] ack_cycle_error_flag_lvl,
  input  wire logic [3:0] dly,
  input  wire logic       berr_cmd,
  output logic            ack_cycle_error_flag_done,
  output logic            ack_cycle_error_flag_berr,
  output logic [7:0]      ack_cycle_error_flag_statid
);
  logic [3:0] cnt_q;

  // Outside a done pulse statid toggles (berr toggles only while idle), so stale values never look valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q       <= 4'h0;
      ack_cycle_error_flag_done   <= 1'b0;
      ack_cycle_error_flag_berr   <= 1'b0;
      ack_cycle_error_flag_statid <= 8'h00;
    end else if (ack_cycle_error_flag_done || !ack_cycle_error_flag_req) begin
      cnt_q       <= 4'h0;
      ack_cycle_error_flag_done   <= 1'b0;
      ack_cycle_error_flag_berr   <= ~ack_cycle_error_flag_berr;
      ack_cycle_error_flag_statid <= ~ack_cycle_error_flag_statid;
    end else if (cnt_q == dly) begin
      ack_cycle_error_flag_done   <= 1'b1;
      ack_cycle_error_flag_berr   <= berr_cmd;
      ack_cycle_error_flag_statid <= {5'h15, ack_cycle_error_flag_lvl};
    end else begin
      cnt_q       <= cnt_q + 4'h1;
      ack_cycle_error_flag_statid <= ~ack_cycle_error_flag_statid;
    end
  end
endmodule

//--- vme_interrupt_handler_router_bench.sv
// Self-checking bench for ivh_top with an acknowledge-cycle model.
// Assumes APB answers after one wait state and a 20 MHz pclk.
`timescale 1ns/100ps
`include "ivh_consts.svh"

module vme_interrupt_handler_router_bench;
  typedef struct packed {logic [7:0] a; logic [31:0] e; logic r;} ivh_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr, ack_cycle_error_flag_statid, host_irq_out_lines;
  logic [31:0] pwdata, prdata, rd, lmap;
  logic [7:1]  vme_irq_n, vme_irq_out;
  logic        sysfail_n, acfail_n, tgt_req, dma_req, tgt_gnt, dma_gnt, int_gnt;
  logic        ack_cycle_error_flag_req, ack_cycle_error_flag_done, ack_cycle_error_flag_berr, sw_ack_done, berr_cmd;
  logic [1:0]  vme_breq_level;
  logic [2:0]  ack_cycle_error_flag_lvl, sw_ack_lvl;
  logic [4:0]  evt;
  logic [3:0]  dly;
  int          error_cnt, compares;
  ivh_row_t    rows [6];

  ivh_top dut_u (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vme_irq_n(vme_irq_n), .sysfail_n(sysfail_n),
    .acfail_n(acfail_n), .tgt_req(tgt_req), .dma_req(dma_req), .tgt_gnt(tgt_gnt),
    .dma_gnt(dma_gnt), .int_gnt(int_gnt), .vme_breq_level(vme_breq_level),
    .ack_cycle_error_flag_req(ack_cycle_error_flag_req), .ack_cycle_error_flag_lvl(ack_cycle_error_flag_lvl), .ack_cycle_error_flag_done(ack_cycle_error_flag_done),
    .ack_cycle_error_flag_berr(ack_cycle_error_flag_berr), .ack_cycle_error_flag_statid(ack_cycle_error_flag_statid), .sw_ack_done(sw_ack_done),
    .sw_ack_lvl(sw_ack_lvl), .dma_evt(evt[0]), .mbox_evt(evt[1]),
    .abort_evt(evt[2]), .lm_evt(evt[3]), .own_evt(evt[4]),
    .host_irq_out_lines(host_irq_out_lines), .vme_irq_out(vme_irq_out)
  );

  ivh_ack_cycle_error_flag_model mdl_u (
    .pclk(pclk), .presetn(presetn), .ack_cycle_error_flag_req(ack_cycle_error_flag_req), .ack_cycle_error_flag_lvl(ack_cycle_error_flag_lvl),
    .dly(dly), .berr_cmd(berr_cmd), .ack_cycle_error_flag_done(ack_cycle_error_flag_done), .ack_cycle_error_flag_berr(ack_cycle_error_flag_berr),
    .ack_cycle_error_flag_statid(ack_cycle_error_flag_statid)
  );

  // *****
  // Tasks
  // *****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  // Called just after a rising edge; leaves one idle cycle before returning
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a transfer that never gets its answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic wait_req(input logic v);
    int n;
    n = 0;
    while (ack_cycle_error_flag_req !== v && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (ack_cycle_error_flag_req !== v) begin
      error_cnt++;
      $display("[ERR] %0t ack request wait timed out", $time);
    end
  endtask

  task automatic pulse_ack(input logic [2:0] l);
    sw_ack_lvl  <= l;
    sw_ack_done <= 1'b1;
    @(posedge pclk);
    sw_ack_done <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic give_verdict;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // *****
  // Stimulus
  // *****
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, tgt_req, dma_req, berr_cmd} <= '0;
    {sw_ack_done, sw_ack_lvl, evt, presetn} <= '0;
    {vme_irq_n, sysfail_n, acfail_n} <= '1;
    dly <= 4'h6;
    rows[0] = {8'h00, `IVH_LEN_MASK, 1'b0};
    rows[1] = {8'h08, `IVH_LMAP_MASK, 1'b0};
    rows[2] = {8'h0C, `IVH_SMAP_MASK, 1'b0};
    rows[3] = {8'h18, `IVH_VMAP_MASK, 1'b0};
    rows[4] = {8'h1C, `IVH_MCTL_MASK, 1'b0};
    rows[5] = {8'h5C, 32'h0, 1'b1};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      rdchk(rows[i].a, 32'h0);
      chk(32'(rerr), 32'(rows[i].r));
      apb(1'b1, rows[i].a, 32'hFFFF_FFFF);
      chk(32'(rerr), 32'(rows[i].r));
      rdchk(rows[i].a, rows[i].e);
    end
    lmap = 32'h0;
    for (int l = 1; l < 8; l++) begin
      rdchk(8'(8'h40 + 4 * (l - 1)), 32'h0);
      lmap = lmap | (32'(l) << (3 * l));
    end
    apb(1'b1, 8'h08, lmap);
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b1, 8'h1C, 32'h2);
    chk(32'(vme_breq_level), 32'h2);
    // Higher level arrives after the first is latched
    vme_irq_n[3] <= 1'b0;
    repeat (2) @(posedge pclk);
    vme_irq_n[6] <= 1'b0;
    wait_req(1'b1);
    chk(32'(ack_cycle_error_flag_lvl), 32'h3);
    chk(32'(host_irq_out_lines), 32'h0);
    wait_req(1'b0);
    wait_req(1'b1);
    chk(32'(ack_cycle_error_flag_lvl), 32'h6);
    wait_req(1'b0);
    repeat (20) @(posedge pclk);
    chk(32'(ack_cycle_error_flag_req), 32'h0);
    chk(32'(host_irq_out_lines), 32'h48);
    rdchk(8'h48, 32'hAB);
    rdchk(8'h54, 32'hAE);
    rdchk(8'h04, 32'h48);
    apb(1'b1, 8'h04, 32'h8);
    wait_req(1'b1);
    chk({29'h0, ack_cycle_error_flag_lvl}, 32'h3);
    chk(32'(host_irq_out_lines), 32'h40);
    vme_irq_n <= 7'h7F;
    wait_req(1'b0);
    apb(1'b1, 8'h04, 32'h48);
    // Bus error on a level raised while the target channel owns the interface
    tgt_req  <= 1'b1;
    berr_cmd <= 1'b1;
    repeat (3) @(posedge pclk);
    dma_req      <= 1'b1;
    vme_irq_n[5] <= 1'b0;
    repeat (10) @(posedge pclk);
    chk({30'h0, tgt_gnt, int_gnt}, 32'h2);
    tgt_req <= 1'b0;
    wait_req(1'b1);
    chk({28'h0, dma_gnt, ack_cycle_error_flag_lvl}, 32'h5);
    wait_req(1'b0);
    {vme_irq_n, berr_cmd, dma_req} <= {7'h7F, 2'b00};
    repeat (4) @(posedge pclk);
    chk(32'(host_irq_out_lines), 32'h21);
    rdchk(8'h50, 32'h100 | 32'hAD);
    rdchk(8'h04, 32'h420);
    rdchk(8'h20, 32'hB);
    apb(1'b1, 8'h04, 32'h420);
    apb(1'b1, 8'h20, 32'h0);
    {sysfail_n, acfail_n} <= 2'b00;
    repeat (30) @(posedge pclk);
    chk(32'(ack_cycle_error_flag_req), 32'h0);
    rdchk(8'h04, 32'h300);
    {sysfail_n, acfail_n} <= 2'b11;
    apb(1'b1, 8'h04, 32'h300);
    // Internal events routed to either bus
    apb(1'b1, 8'h18, 32'h402);
    apb(1'b1, 8'h10, 32'h400);
    for (int i = 0; i < 5; i++) begin
      evt[i] <= 1'b1;
      @(posedge pclk);
      evt[i] <= 1'b0;
    end
    repeat (3) @(posedge pclk);
    rdchk(8'h04, 32'h1B800);
    chk(32'(vme_irq_out), 32'h08);
    apb(1'b1, 8'h14, 32'h400);
    apb(1'b1, 8'h04, 32'h1B800);
    // Software interrupts, both methods on level two
    apb(1'b1, 8'h10, 32'h404);
    rdchk(8'h14, 32'h4);
    chk(32'(vme_irq_out), 32'h02);
    apb(1'b1, 8'h10, 32'h504);
    rdchk(8'h14, 32'h104);
    pulse_ack(3'h2);
    rdchk(8'h14, 32'h4);
    chk(32'(vme_irq_out), 32'h02);
    rdchk(8'h04, 32'h4000);
    pulse_ack(3'h2);
    rdchk(8'h14, 32'h0);
    chk(32'(vme_irq_out), 32'h0);
    apb(1'b1, 8'h10, 32'h504);
    rdchk(8'h14, 32'h0);
    apb(1'b1, 8'h10, 32'h400);
    apb(1'b1, 8'h10, 32'h404);
    rdchk(8'h14, 32'h4);
    // Reset in mid-run: pending software line and status must all drop
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(vme_irq_out), 32'h0);
    chk(32'(host_irq_out_lines), 32'h0);
    rdchk(8'h14, 32'h0);
    rdchk(8'h04, 32'h0);
    rdchk(8'h00, 32'h0);
    give_verdict();
  end
endmodule
